// ===== spp_monitor.sv
// Bus voltage window for one sink profile.
`timescale 1ns/1ps
module spp_monitor (
   input wire logic [15:0] i_nominal_mv,
   input wire logic i_first,
   input wire logic i_attached,
   output spp_pkg::spp_window_t o_window
);
   logic [22:0] up_prod;
   logic [22:0] lo_prod;
   always_comb begin
      // [R10] Window limits computed.
      up_prod = i_nominal_mv * (i_first ? spp_pkg::UPPER1_PCT :
         spp_pkg::UPPERN_PCT);
      lo_prod = i_nominal_mv * spp_pkg::ATTACH_PCT;
      o_window.high_mv = 16'(up_prod / spp_pkg::PCT_DIV);
      if (i_first && i_attached) begin
         o_window.low_mv = spp_pkg::DETACH_FLOOR_MV;
      end else begin
         o_window.low_mv = 16'(lo_prod / spp_pkg::PCT_DIV);
      end
   end
endmodule

// ===== spp_pkg.sv
// Package of constants and types for the sink power path control block.
// Notes on behaviour
// [R1] After power-up or reset the block loads its host-visible settings from the non-volatile store during a load interval.
// [R2] The host must not make its first register access before the load interval has fully elapsed.
// [R3] At power-up the load starts when the core regulator reaches its good level and the internal power-on reset releases.
// [R4] After an external reset the load starts at the release of the reset input.
// [R5] With high-voltage-only set, the path enable is asserted only after an explicit second or third profile contract.
// [R6] After a mismatch in high-voltage-only mode the path stays open at 5 V, the block stays attached and accepts source renegotiation.
// [R7] When a later negotiation succeeds the path enable is asserted at the negotiated profile.
// [R8] Implicit 5 V or first profile drives only the path enable; second adds output A; third adds output B.
// [R9] Three default profiles: fixed 5 V 1.5 A low, flexible 15 V 1.5 A medium, flexible 20 V 1.0 A high priority.
// [R10] Bus monitoring uses a 3.3 V detach floor, -20 % attach and +15 % upper for profile one, and -20 % and +10 % for the others.
// [R11] With both supplies present the low-voltage system supply is used when above 3.1 V, else the bus-derived supply.
// [R12] With high-voltage-only clear, the path enable follows attachment whatever the bus voltage.
package spp_pkg;
   localparam int unsigned LOAD_TIME_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned LOAD_CYCLES =
      (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] LOAD_CYCLES_W = 8'(LOAD_CYCLES - 1);
   // Voltages in millivolts, currents in milliamps.
   localparam logic [15:0] SYS_SUPPLY_SEL_MV = 16'h0c1c;
   localparam logic [15:0] DETACH_FLOOR_MV = 16'h0ce4;
   localparam logic [3:0] LOW_MARGIN_PCT = 4'h0;
   localparam logic [6:0] ATTACH_PCT = 7'h50;
   localparam logic [6:0] UPPER1_PCT = 7'h73;
   localparam logic [6:0] UPPERN_PCT = 7'h6e;
   localparam logic [6:0] PCT_DIV = 7'h64;
   localparam logic [15:0] PDO1_MV = 16'h1388;
   localparam logic [15:0] PDO2_MV = 16'h3a98;
   localparam logic [15:0] PDO3_MV = 16'h4e20;
   localparam logic [11:0] PDO1_MA = 12'h5dc;
   localparam logic [11:0] PDO2_MA = 12'h5dc;
   localparam logic [11:0] PDO3_MA = 12'h3e8;
   localparam logic HV_ONLY_RESET = 1'b0;

   typedef enum logic [1:0] {SPP_PRIO_LOW, SPP_PRIO_MED, SPP_PRIO_HIGH}
      spp_prio_t;

   typedef struct packed {
      logic [15:0] mv;
      logic [11:0] ma;
      logic flexible;
      spp_prio_t prio;
   } spp_pdo_t;

   // Contract code: 0 none, 1 implicit 5 V, 2..4 profile one to three.
   typedef enum logic [2:0] {
      SPP_CT_NONE, SPP_CT_IMPLICIT, SPP_CT_PDO1, SPP_CT_PDO2, SPP_CT_PDO3
   } spp_contract_t;

   typedef struct packed {
      logic path_en;
      logic hp_a;
      logic hp_b;
   } spp_outs_t;

   typedef struct packed {
      logic [15:0] low_mv;
      logic [15:0] high_mv;
   } spp_window_t;
endpackage

// ===== spp_source_model.sv
// Behavioural USB PD source that attaches and settles contracts.
`timescale 1ns/1ps
module spp_source_model (
   input wire logic i_clk_sys,
   output logic o_attached,
   output spp_pkg::spp_contract_t o_contract,
   output logic [15:0] o_vbus_mv
);
   initial begin
      o_attached = 1'b0;
      o_contract = spp_pkg::SPP_CT_NONE;
      o_vbus_mv = 16'h0000;
   end
   // Source renegotiation
   // The source attaches and settles a new contract and bus level.
   task automatic offer(input spp_pkg::spp_contract_t ct,
                        input logic [15:0] mv);
      @(negedge i_clk_sys);
      o_attached = 1'b1;
      o_contract = ct;
      o_vbus_mv = mv;
   endtask
   // The source leaves and the bus drops to zero.
   task automatic detach();
      @(negedge i_clk_sys);
      o_attached = 1'b0;
      o_contract = spp_pkg::SPP_CT_NONE;
      o_vbus_mv = 16'h0000;
   endtask
endmodule

// ===== spp_top.sv
// Sink power path control: settings load, profiles and path outputs.
`timescale 1ns/1ps
module spp_top (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   input wire logic i_nvm_hv_only,
   input wire logic i_attached,
   input wire spp_pkg::spp_contract_t i_contract,
   input wire logic [15:0] i_vbus_mv,
   input wire logic [15:0] i_sys_supply_mv,
   input wire logic i_vdd_present,
   input wire logic [1:0] i_pdo_sel,
   output logic o_load_done,
   output logic o_high_voltage_only_cfg,
   output logic o_sink_path_enable_out,
   output logic o_high_profile_a_ok,
   output logic o_high_profile_b_ok,
   output logic o_use_system_supply,
   output logic o_vbus_in_window,
   output spp_pkg::spp_pdo_t o_pdo,
   output spp_pkg::spp_window_t o_window
);
   logic por_meta_reg;
   logic por_sync_reg;
   logic att_meta_reg;
   logic att_sync_reg;
   logic [7:0] load_cnt_reg;
   logic load_done_reg;
   logic hv_only_reg;
   spp_pkg::spp_outs_t outs_reg;
   spp_pkg::spp_outs_t outs_next;
   logic use_sys_reg;
   logic in_win_reg;
   spp_pkg::spp_pdo_t pdo_reg;
   spp_pkg::spp_pdo_t pdo_next;
   spp_pkg::spp_window_t win_reg;
   spp_pkg::spp_window_t win_c;
   spp_pkg::spp_contract_t ct_c;

   // The i_por_n and i_attached pins pass two flip-flops.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         por_meta_reg <= 1'b0;
         por_sync_reg <= 1'b0;
         att_meta_reg <= 1'b0;
         att_sync_reg <= 1'b0;
      end else begin
         por_meta_reg <= i_por_n;
         por_sync_reg <= por_meta_reg;
         att_meta_reg <= i_attached;
         att_sync_reg <= att_meta_reg;
      end
   end

   // [R3] [R4] Load starts at release.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !por_sync_reg) begin
         load_cnt_reg <= 8'h00;
         load_done_reg <= 1'b0;
      end else if (!load_done_reg) begin
         if (load_cnt_reg == spp_pkg::LOAD_CYCLES_W) begin
            load_done_reg <= 1'b1;
         end
         load_cnt_reg <= load_cnt_reg + 8'h01;
      end
   end

   // [R1] Settings loaded from store.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !por_sync_reg) begin
         hv_only_reg <= spp_pkg::HV_ONLY_RESET;
      end else if (!load_done_reg &&
            load_cnt_reg == spp_pkg::LOAD_CYCLES_W) begin
         hv_only_reg <= i_nvm_hv_only;
      end
   end

   assign ct_c = att_sync_reg ? i_contract : spp_pkg::SPP_CT_NONE;

   always_comb begin
      outs_next = '0;
      // [R8] Contract to outputs.
      unique case (ct_c)
         spp_pkg::SPP_CT_NONE: outs_next = '0;
         spp_pkg::SPP_CT_IMPLICIT, spp_pkg::SPP_CT_PDO1: begin
            // [R6] Open path at 5 V.
            outs_next.path_en = !hv_only_reg;
         end
         spp_pkg::SPP_CT_PDO2: begin
            // [R5] [R7] Explicit high contract.
            outs_next.path_en = 1'b1;
            outs_next.hp_a = 1'b1;
         end
         spp_pkg::SPP_CT_PDO3: begin
            outs_next.path_en = 1'b1;
            outs_next.hp_b = 1'b1;
         end
         default: outs_next = '0;
      endcase
      // [R12] Attached without gating.
      if (ct_c == spp_pkg::SPP_CT_NONE && att_sync_reg && !hv_only_reg) begin
         outs_next.path_en = 1'b1;
      end
      if (!load_done_reg) begin
         outs_next = '0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !por_sync_reg) begin
         outs_reg <= '0;
      end else begin
         outs_reg <= outs_next;
      end
   end

   // [R9] Default profile table.
   always_comb begin
      unique case (i_pdo_sel)
         2'h1: pdo_next = '{spp_pkg::PDO2_MV, spp_pkg::PDO2_MA, 1'b1,
            spp_pkg::SPP_PRIO_MED};
         2'h2: pdo_next = '{spp_pkg::PDO3_MV, spp_pkg::PDO3_MA, 1'b1,
            spp_pkg::SPP_PRIO_HIGH};
         default: pdo_next = '{spp_pkg::PDO1_MV, spp_pkg::PDO1_MA, 1'b0,
            spp_pkg::SPP_PRIO_LOW};
      endcase
   end

   spp_monitor u_mon (
      .i_nominal_mv(pdo_next.mv),
      .i_first(i_pdo_sel != 2'h1 && i_pdo_sel != 2'h2),
      .i_attached(att_sync_reg),
      .o_window(win_c)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pdo_reg <= '0;
         win_reg <= '0;
         in_win_reg <= 1'b0;
         use_sys_reg <= 1'b0;
      end else begin
         pdo_reg <= pdo_next;
         win_reg <= win_c;
         // [R10] Bus checked against window.
         in_win_reg <= i_vbus_mv >= win_c.low_mv &&
            i_vbus_mv <= win_c.high_mv;
         // [R11] Supply selection.
         use_sys_reg <= !i_vdd_present ||
            i_sys_supply_mv > spp_pkg::SYS_SUPPLY_SEL_MV;
      end
   end

   assign o_load_done = load_done_reg;
   assign o_high_voltage_only_cfg = hv_only_reg;
   assign o_sink_path_enable_out = outs_reg.path_en;
   assign o_high_profile_a_ok = outs_reg.hp_a;
   assign o_high_profile_b_ok = outs_reg.hp_b;
   assign o_use_system_supply = use_sys_reg;
   assign o_vbus_in_window = in_win_reg;
   assign o_pdo = pdo_reg;
   assign o_window = win_reg;

   property p_hv_gate;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_high_voltage_only_cfg && o_sink_path_enable_out) |->
         (o_high_profile_a_ok || o_high_profile_b_ok);
   endproperty
   a_hv_gate: assert property (p_hv_gate) // [R5]
      else $error("Path enabled at 5 V.");

   property p_excl;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !(o_high_profile_a_ok && o_high_profile_b_ok);
   endproperty
   a_excl: assert property (p_excl) // [R8]
      else $error("Both high outputs set.");

   property p_hp_path;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_high_profile_a_ok || o_high_profile_b_ok) |-> o_sink_path_enable_out;
   endproperty
   a_hp_path: assert property (p_hp_path) // [R8]
      else $error("High without path.");

   property p_no_load;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_load_done |-> !o_sink_path_enable_out;
   endproperty
   a_no_load: assert property (p_no_load) // [R1]
      else $error("Path before load.");

   property p_load_len;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(por_sync_reg) |-> !o_load_done [*8];
   endproperty
   a_load_len: assert property (p_load_len) // [R3]
      else $error("Load too short.");

   property p_load_end;
      @(posedge i_clk_sys) disable iff (!i_rst_n || !por_sync_reg)
      $rose(por_sync_reg) |-> ##[1:300] o_load_done;
   endproperty
   a_load_end: assert property (p_load_end) // [R4]
      else $error("Load never ends.");

   property p_pdo2;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_load_done && por_sync_reg && att_sync_reg &&
         i_contract == spp_pkg::SPP_CT_PDO2 && $stable(o_load_done))
         |=> o_high_profile_a_ok;
   endproperty
   a_pdo2: assert property (p_pdo2) // [R7]
      else $error("Profile two missed.");

   property p_nohv;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_load_done && por_sync_reg && !hv_only_reg && att_sync_reg) |=>
         (o_sink_path_enable_out || !$past(att_sync_reg) ||
            $changed(hv_only_reg));
   endproperty
   a_nohv: assert property (p_nohv) // [R12]
      else $error("Path off when attached.");

   property p_supply;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_vdd_present && i_sys_supply_mv <= spp_pkg::SYS_SUPPLY_SEL_MV) |=>
         !o_use_system_supply;
   endproperty
   a_supply: assert property (p_supply) // [R11]
      else $error("System supply picked below threshold.");

   property p_detached;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !att_sync_reg |=> !o_sink_path_enable_out;
   endproperty
   a_detached: assert property (p_detached) // [R12]
      else $error("Path enabled while detached.");
endmodule

// ===== testbench.sv
// Testbench for the sink power path control block.
`timescale 1ns/1ps
module testbench;
   logic i_clk_sys, i_rst_n, i_por_n, i_nvm_hv_only, i_vdd_present;
   logic [15:0] i_sys_supply_mv;
   logic [1:0] i_pdo_sel;
   logic attached;
   spp_pkg::spp_contract_t contract;
   logic [15:0] vbus;
   logic done, hv, path, hpa, hpb, use_sys, in_win;
   spp_pkg::spp_pdo_t pdo;
   spp_pkg::spp_window_t win;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   spp_source_model spp_source_model_i (.i_clk_sys(i_clk_sys),
      .o_attached(attached), .o_contract(contract), .o_vbus_mv(vbus));
   spp_top spp_top_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_por_n(i_por_n), .i_nvm_hv_only(i_nvm_hv_only),
      .i_attached(attached), .i_contract(contract), .i_vbus_mv(vbus),
      .i_sys_supply_mv(i_sys_supply_mv), .i_vdd_present(i_vdd_present),
      .i_pdo_sel(i_pdo_sel), .o_load_done(done),
      .o_high_voltage_only_cfg(hv), .o_sink_path_enable_out(path),
      .o_high_profile_a_ok(hpa), .o_high_profile_b_ok(hpb),
      .o_use_system_supply(use_sys), .o_vbus_in_window(in_win),
      .o_pdo(pdo), .o_window(win));
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   task automatic end_of_test();
      $display("fails=%0d comparisons=%0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic wait_load();
      int k;
      for (k = 0; k < 300 && done !== 1'b1; k++) begin
         chk({path, hpa, hpb}, 32'h0);
         @(negedge i_clk_sys);
      end
      chk(done, 1'b1);
      chk(k > 245, 1'b1);
   endtask
   task automatic t_reset(input logic hv_bit);
      i_nvm_hv_only = hv_bit;
      i_rst_n = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      chk(done, 1'b0);
      i_rst_n = 1'b1;
      wait_load();
      chk(hv, hv_bit);
   endtask
   task automatic t_por();
      i_por_n = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      chk(done, 1'b0);
      i_por_n = 1'b1;
      wait_load();
      @(negedge i_clk_sys);
      chk(hv, 1'b1);
      chk({path, hpa, hpb}, 32'h5);
   endtask
   task automatic t_contracts(input logic hv_bit);
      logic [2:0] e;
      for (int c = 0; c < 5; c++) begin
         spp_source_model_i.offer(spp_pkg::spp_contract_t'(c), 16'h1388);
         repeat (4) @(negedge i_clk_sys);
         e = {hv_bit ? c >= 3 : 1'b1, c == 3, c == 4};
         chk({path, hpa, hpb}, e);
      end
   endtask
   task automatic t_detach();
      spp_source_model_i.detach();
      repeat (4) @(negedge i_clk_sys);
      chk({path, hpa, hpb}, 32'h0);
      chk(win, {16'h0fa0, 16'h1676});
      chk(in_win, 1'b0);
   endtask
   task automatic t_profiles();
      spp_source_model_i.offer(spp_pkg::SPP_CT_PDO2, 16'h3a98);
      i_pdo_sel = 2'h0;
      repeat (4) @(negedge i_clk_sys);
      chk(pdo, {16'h1388, 12'h5dc, 1'b0, spp_pkg::SPP_PRIO_LOW});
      chk(win, {16'h0ce4, 16'h1676});
      i_pdo_sel = 2'h1;
      repeat (4) @(negedge i_clk_sys);
      chk(pdo, {16'h3a98, 12'h5dc, 1'b1, spp_pkg::SPP_PRIO_MED});
      chk(win, {16'h2ee0, 16'h4074});
      chk(in_win, 1'b1);
      spp_source_model_i.offer(spp_pkg::SPP_CT_PDO2, 16'h4100);
      repeat (4) @(negedge i_clk_sys);
      chk(in_win, 1'b0);
      i_pdo_sel = 2'h2;
      repeat (4) @(negedge i_clk_sys);
      chk(pdo, {16'h4e20, 12'h3e8, 1'b1, spp_pkg::SPP_PRIO_HIGH});
      chk(win, {16'h3e80, 16'h55f0});
      chk(in_win, 1'b1);
      i_pdo_sel = 2'h3;
      repeat (4) @(negedge i_clk_sys);
      chk(pdo, {16'h1388, 12'h5dc, 1'b0, spp_pkg::SPP_PRIO_LOW});
   endtask
   task automatic t_supply();
      i_sys_supply_mv = 16'h0c1d;
      repeat (4) @(negedge i_clk_sys);
      chk(use_sys, 1'b1);
      i_sys_supply_mv = 16'h0c1c;
      repeat (4) @(negedge i_clk_sys);
      chk(use_sys, 1'b0);
      i_vdd_present = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      chk(use_sys, 1'b1);
      i_vdd_present = 1'b1;
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_por_n = 1'b1;
      i_nvm_hv_only = 1'b0;
      i_vdd_present = 1'b1;
      i_sys_supply_mv = 16'h1388;
      i_pdo_sel = 2'h0;
      t_reset(1'b0);
      t_contracts(1'b0);
      t_detach();
      t_profiles();
      t_supply();
      t_reset(1'b1);
      t_contracts(1'b1);
      t_por();
      end_of_test();
   end
endmodule
